// ---- hdl/rlse_pkg.sv ----
`default_nettype none
package rlse_pkg;
  localparam int          LANES      = 12;     // Serial lanes
  localparam int          CHANS      = 16;     // Receive channels
  localparam int          CH_W       = 4;      // Channel number width
  localparam int          DATA_W     = 64;     // One data word per beat
  localparam logic [15:0] MFLEN_RST  = 16'h0800; // Meta Frame length, words
  localparam logic [15:0] BSHORT_RST = 16'h0040; // BurstShort, bytes
  localparam int          BSHORT_SH  = 3;      // Bytes to words shift
  localparam logic [2:0]  BUS_MASK   = 3'h7;   // Bus width is 8 words
  localparam logic [2:0]  SW_REP_LIM = 3'h4;   // Bad sync words in a row
  localparam logic [1:0]  SS_REP_LIM = 2'h3;   // Bad scrambler words in a row
  // Avalon byte offsets
  localparam logic [3:0]  REG_MFLEN  = 4'h0;
  localparam logic [3:0]  REG_BSHORT = 4'h4;
  localparam logic [3:0]  REG_LANE   = 4'h8;
  localparam logic [3:0]  REG_ALIGN  = 4'hC;
  localparam int          ALIGN_OK_B  = 0;     // Field positions in REG_ALIGN
  localparam int          ALIGN_ERR_B = 1;

  // Bus slave states, one-hot
  typedef enum logic [1:0] {
    RLSE_AV_IDLE = 2'b01,
    RLSE_AV_DONE = 2'b10
  } rlse_av_t;

  // Per-lane word decoder events, one bit per lane
  typedef struct packed {
    logic [LANES-1:0] word_lock;  // Word boundary lock held
    logic [LANES-1:0] lock_fail;  // Framing bits cannot reach lock
    logic [LANES-1:0] word_vld;   // One word received
    logic [LANES-1:0] frame_bad;  // Illegal framing bits
    logic [LANES-1:0] sw_ok;      // Valid sync word
    logic [LANES-1:0] sw_bad;     // Invalid sync word
    logic [LANES-1:0] ss_ok;      // Expected scrambler state word
    logic [LANES-1:0] ss_bad;     // Unexpected scrambler state word
  } rlse_lane_in_t;

  // Received control word events
  typedef struct packed {
    logic valid;    // Control word seen
    logic burst;    // It is a Burst Control Word
    logic crc_bad;  // CRC24 mismatch
  } rlse_cw_t;

  // One local bus beat
  typedef struct packed {
    logic              ena;
    logic              sop;
    logic              eop;
    logic              err;
    logic [CH_W-1:0]   chan;
    logic [DATA_W-1:0] data;
  } rlse_beat_t;

  // Per-lane status outputs
  typedef struct packed {
    logic [LANES-1:0] locked;
    logic [LANES-1:0] lock_failure;
    logic [LANES-1:0] frame_length_error;
    logic [LANES-1:0] repeat_invalid_error;
    logic [LANES-1:0] descrambler_error;
    logic [LANES-1:0] sync_word_error;
    logic [LANES-1:0] framing_error;
  } rlse_lane_stat_t;

  // Whole block state
  typedef struct packed {
    rlse_lane_stat_t   st;
    logic [LANES-1:0]  sw_seen;
    logic [LANES-1:0]  lock_q;
    logic [LANES*16-1:0] mf_cnt;
    logic [LANES*3-1:0]  sw_run;
    logic [LANES*2-1:0]  ss_run;
    logic              aligned;
    logic              was_aligned;
    logic              align_err;
    logic              crc_err;
    logic              burst_err;
    logic              msop;
    logic              meop;
    logic              bcw_seen;
    logic [15:0]       gap;
    logic [15:0]       bwords;
    logic              last_eop;
    logic [CHANS-1:0]  open;
    logic [CHANS-1:0]  perr;
    rlse_beat_t        beat;
    rlse_av_t          av;
    logic [31:0]       rdata;
    logic [15:0]       mflen;
    logic [15:0]       bshort;
  } rlse_state_t;
endpackage : rlse_pkg
`default_nettype wire

// ---- hdl/rlse_lane_sync_status.sv ----
// Operation
// - Lock bit high only when lane fully healthy
// - Lock bit low on no lock or error
// - Lock failure on framing trouble or no sync
// - Sticky lane errors clear on relock or other
// - Frame length error on wrong sync spacing
// - Repeat error: 4 bad sync, 3 bad scrambler
// - Descrambler error pulse after lock only
// - Sync word error pulse after lock only
// - Aligned only when all lanes deskewed
// - Alignment error on give-up or loss
// - Framing error pulse per illegal pattern; here only while word lock is held
// - Framing error after alignment acts as CRC
// - CRC24 error one-cycle pulse per mismatch
// - CRC error marks all open packets errored
// - Missing start: pulse, insert start, error
// - Missing end: pulse, drop start, merge, error
// - Burst error pulse, treated as CRC error
// - BurstShort violation on close burst words
// - Burst length not multiple of bus width
// - All outputs change on clock edges only, except avs_waitrequest
//
// Our own choices: the Avalon-MM slave port and the placing of the registers.
`default_nettype none
module rlse_lane_sync_status
  import rlse_pkg::*;
(
  input  wire logic            clk_i,       // Local bus clock
  input  wire logic            rst_i,       // Synchronous, active high
  input  wire rlse_lane_in_t   lane_i,      // Lane decoder events
  input  wire logic            deskew_i,    // All lanes deskewed
  input  wire logic            give_up_i,   // Alignment attempts exhausted
  input  wire rlse_cw_t        cw_i,        // Control word events
  input  wire rlse_beat_t      beat_i,      // Raw received beat
  input  wire logic [3:0]      avs_address,
  input  wire logic            avs_read,
  input  wire logic            avs_write,
  input  wire logic [31:0]     avs_writedata,
  output logic [31:0]          avs_readdata,
  output logic                 avs_waitrequest,
  output rlse_lane_stat_t      lane_stat_o,  // Per-lane status
  output logic                 aligned_o,
  output logic                 align_err_o,
  output logic                 crc_err_o,
  output logic                 burst_err_o,
  output logic                 missing_start_error_o,
  output logic                 missing_end_error_o,
  output rlse_beat_t           beat_o        // Repaired beat
);

  rlse_state_t q;        // Registered state
  rlse_state_t next_q;   // Next state

  // True when a burst ends off the bus-width grid
  function automatic logic rlse_off_grid(input logic [15:0] w);
    rlse_off_grid = (w[2:0] & BUS_MASK) != 3'h0;
  endfunction : rlse_off_grid

  // Register decode for reads
  function automatic logic [31:0] rlse_rd(input rlse_state_t s,
                                          input logic [3:0] a);
    rlse_rd = 32'h0;
    // Read-only and unmapped places ignore writes
    case (a)
      REG_MFLEN:  rlse_rd = {16'h0, s.mflen};
      REG_BSHORT: rlse_rd = {16'h0, s.bshort};
      REG_LANE:   rlse_rd = {20'h0, s.st.locked};
      REG_ALIGN: begin
        rlse_rd[ALIGN_OK_B]  = s.aligned;
        rlse_rd[ALIGN_ERR_B] = s.align_err;
      end
      default:    rlse_rd = 32'h0;  // Unmapped reads zero
    endcase
  endfunction : rlse_rd

  // Combinational next-state logic
  always_comb begin
    // Scratch values, rebuilt every cycle
    logic              cw_err;   // Anything that counts as CRC24 error
    logic              bviol;    // Burst violation this cycle
    logic [15:0]       cnt;
    logic [2:0]        swr;
    logic [1:0]        ssr;
    logic              fail;
    logic              lenb;
    logic              repb;
    logic [CH_W-1:0]   ch;
    cw_err = 1'b0;
    bviol  = 1'b0;
    cnt    = 16'h0;
    swr    = 3'h0;
    ssr    = 2'h0;
    fail   = 1'b0;
    lenb   = 1'b0;
    repb   = 1'b0;
    ch     = beat_i.chan;
    next_q = q;
    // Last lock level, for the relock edge
    next_q.lock_q = lane_i.word_lock;

    // Per-lane monitoring
    for (int l = 0; l < LANES; l++) begin
      cnt = q.mf_cnt[l*16 +: 16];
      swr = q.sw_run[l*3 +: 3];
      ssr = q.ss_run[l*2 +: 2];
      // Pulses only after lock
      next_q.st.descrambler_error[l] =
        lane_i.word_lock[l] & lane_i.ss_bad[l];
      next_q.st.sync_word_error[l] =
        lane_i.word_lock[l] & lane_i.sw_bad[l];
      next_q.st.framing_error[l] =
        lane_i.word_lock[l] & lane_i.frame_bad[l];
      if (!lane_i.word_lock[l]) begin
        // Counters restart while unlocked
        cnt = 16'h0;
        swr = 3'h0;
        ssr = 2'h0;
        next_q.sw_seen[l] = 1'b0;
        fail = lane_i.lock_fail[l];
        lenb = q.st.frame_length_error[l];
        repb = q.st.repeat_invalid_error[l];
      end else begin
        if (lane_i.word_vld[l]) begin
          cnt = cnt + 16'h1;
        end
        // Spacing of sync words against configured length
        lenb = 1'b0;
        if (lane_i.sw_ok[l] | lane_i.sw_bad[l]) begin
          lenb = q.sw_seen[l] & (cnt != q.mflen);
          cnt = 16'h0;
        end
        // Saturating runs of bad words
        if (lane_i.sw_ok[l]) begin
          next_q.sw_seen[l] = 1'b1;
          swr = 3'h0;
        end else if (lane_i.sw_bad[l] && swr != SW_REP_LIM) begin
          swr = swr + 3'h1;
        end
        if (lane_i.ss_ok[l]) begin
          ssr = 2'h0;
        end else if (lane_i.ss_bad[l] && ssr != SS_REP_LIM) begin
          ssr = ssr + 2'h1;
        end
        repb = (lane_i.sw_bad[l] && swr == SW_REP_LIM) ||
               (lane_i.ss_bad[l] && ssr == SS_REP_LIM);
        // Framing trouble, or sync word overdue by a frame
        fail = lane_i.frame_bad[l] ||
               (!q.sw_seen[l] && cnt > q.mflen);
      end
      next_q.mf_cnt[l*16 +: 16] = cnt;
      next_q.sw_run[l*3 +: 3]   = ssr == 2'h0 && swr == 3'h0 ? 3'h0 : swr;
      next_q.ss_run[l*2 +: 2]   = ssr;
      // Sticky bits: a new failure replaces the others
      // Limitation: relock needs a low cycle first
      if (lane_i.word_lock[l] && !q.lock_q[l]) begin
        // Regained lock clears all
        next_q.st.lock_failure[l]         = 1'b0;
        next_q.st.frame_length_error[l]   = 1'b0;
        next_q.st.repeat_invalid_error[l] = 1'b0;
      end
      if (fail) begin
        next_q.st.lock_failure[l]         = 1'b1;
        next_q.st.frame_length_error[l]   = 1'b0;
        next_q.st.repeat_invalid_error[l] = 1'b0;
      end else if (lenb && lane_i.word_lock[l]) begin
        next_q.st.lock_failure[l]         = 1'b0;
        next_q.st.frame_length_error[l]   = 1'b1;
        next_q.st.repeat_invalid_error[l] = 1'b0;
      end else if (repb && lane_i.word_lock[l]) begin
        next_q.st.lock_failure[l]         = 1'b0;
        next_q.st.frame_length_error[l]   = 1'b0;
        next_q.st.repeat_invalid_error[l] = 1'b1;
      end
      // Healthy lane only
      next_q.st.locked[l] = lane_i.word_lock[l] & next_q.sw_seen[l] &
        ~next_q.st.lock_failure[l] & ~next_q.st.frame_length_error[l] &
        ~next_q.st.repeat_invalid_error[l] &
        ~next_q.st.descrambler_error[l] &
        ~next_q.st.sync_word_error[l] &
        ~next_q.st.framing_error[l];
    end

    // Alignment
    next_q.aligned = deskew_i & (&next_q.st.locked);
    // Error stays until alignment returns
    if (next_q.aligned) begin
      next_q.was_aligned = 1'b1;
      next_q.align_err   = 1'b0;
    end else if (give_up_i || q.was_aligned) begin
      next_q.align_err   = 1'b1;
      next_q.was_aligned = 1'b0;
    end

    // Burst spacing and length on Burst Control Words
    // Gap and length count local bus beats
    if (beat_i.ena) begin
      next_q.gap    = q.gap + 16'h1;
      next_q.bwords = q.bwords + 16'h1;
      // A burst ending with EOP may be short
      next_q.last_eop = beat_i.eop;
    end
    if (cw_i.valid && cw_i.burst) begin
      // First burst word has nothing to compare
      if (q.bcw_seen) begin
        bviol = (q.gap < (q.bshort >> BSHORT_SH)) ||
                (!q.last_eop && rlse_off_grid(q.bwords));
      end
      next_q.bcw_seen = 1'b1;
      next_q.gap      = 16'h0;
      next_q.bwords   = 16'h0;
      next_q.last_eop = 1'b0;
    end
    // CRC24 cannot be tied to one packet,
    // so every open packet takes the error
    cw_err = (cw_i.valid & cw_i.crc_bad) | bviol |
             (q.aligned & (|next_q.st.framing_error));
    next_q.crc_err   = cw_i.valid & cw_i.crc_bad;
    next_q.burst_err = bviol;

    // Packet delineation repair
    next_q.msop = 1'b0;
    next_q.meop = 1'b0;
    next_q.beat = beat_i;
    next_q.beat.err = 1'b0;
    if (cw_err) begin
      next_q.perr = q.perr | q.open;
    end
    if (beat_i.ena) begin
      if (beat_i.sop && q.open[ch]) begin
        // Extra start on an open channel: merge
        next_q.meop     = 1'b1;
        next_q.beat.sop = 1'b0;
        next_q.perr[ch] = 1'b1;
      end else if (!beat_i.sop && !q.open[ch]) begin
        // Data with no start: insert one
        next_q.msop     = 1'b1;
        next_q.beat.sop = 1'b1;
        next_q.perr[ch] = 1'b1;
      end else if (beat_i.sop) begin
        // Clean start opens a fresh packet
        next_q.perr[ch] = beat_i.err | cw_err;
      end
      next_q.open[ch] = 1'b1;
      if (beat_i.eop) begin
        // End closes the packet and reports its error
        next_q.beat.err = next_q.perr[ch] | beat_i.err | cw_err;
        next_q.open[ch] = 1'b0;
        next_q.perr[ch] = 1'b0;
      end
    end

    // Avalon slave: one wait cycle, then answer
    case (q.av)
      RLSE_AV_IDLE: begin
        // Read data captured a cycle early, held
        if (avs_read || avs_write) begin
          next_q.av    = RLSE_AV_DONE;
          next_q.rdata = rlse_rd(q, avs_address);
        end
      end
      RLSE_AV_DONE: begin
        // Writes commit on the edge after the wait, which ends the transfer
        next_q.av = RLSE_AV_IDLE;
        if (avs_write && avs_address == REG_MFLEN) begin
          next_q.mflen = avs_writedata[15:0];
        end
        if (avs_write && avs_address == REG_BSHORT) begin
          next_q.bshort = avs_writedata[15:0];
        end
      end
      default: next_q.av = RLSE_AV_IDLE;
    endcase
  end

  // State register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      // Configuration returns to its defaults
      q        <= '0;
      q.av     <= RLSE_AV_IDLE;
      q.mflen  <= MFLEN_RST;
      q.bshort <= BSHORT_RST;
    end else begin
      q <= next_q;
    end
  end

  // Outputs straight from flops
  assign lane_stat_o           = q.st;
  assign aligned_o             = q.aligned;
  assign align_err_o           = q.align_err;
  assign crc_err_o             = q.crc_err;
  assign burst_err_o           = q.burst_err;
  assign missing_start_error_o = q.msop;
  assign missing_end_error_o   = q.meop;
  assign beat_o                = q.beat;
  assign avs_readdata          = q.rdata;
  // Wait in the first cycle of every request
  // Trade-off: a fixed wait keeps read data in a flop
  assign avs_waitrequest = (avs_read | avs_write) & (q.av == RLSE_AV_IDLE);

  // Checks
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);

  // Lane status, alignment, CRC24, packet repair and slave wait
  lock_health_a: assert property (
    (q.st.locked & (~q.lock_q | q.st.lock_failure |
     q.st.frame_length_error | q.st.repeat_invalid_error)) == '0
  ) else $error("lock bit high on unhealthy lane");
  descr_pulse_a: assert property (
    lane_i.ss_bad[2] && lane_i.word_lock[2] |=> q.st.descrambler_error[2]
  ) else $error("descrambler error not flagged");
  sync_word_a: assert property (
    !lane_i.word_lock[0] |=> !q.st.sync_word_error[0]
  ) else $error("sync word error before lock");
  lock_fail_a: assert property (
    lane_i.word_lock[0] && lane_i.frame_bad[0] |=> q.st.lock_failure[0]
  ) else $error("lock failure not raised");
  aligned_all_a: assert property (
    q.aligned |-> &q.st.locked
  ) else $error("aligned with a lane unlocked");
  align_loss_a: assert property (
    $fell(q.aligned) |-> q.align_err
  ) else $error("alignment loss not flagged");
  crc_pulse_a: assert property (
    crc_err_o == $past(cw_i.valid & cw_i.crc_bad)
  ) else $error("crc error not pulsed");
  msop_insert_a: assert property (
    missing_start_error_o |-> beat_o.sop && beat_o.ena
  ) else $error("missing start not repaired");
  meop_drop_a: assert property (
    missing_end_error_o |-> !beat_o.sop
  ) else $error("extra start not dropped");
  burst_crc_a: assert property (
    burst_err_o |-> (q.open & ~q.perr) == '0
  ) else $error("burst error did not error packet");
  av_wait_a: assert property (
    avs_read && avs_waitrequest |=> !avs_waitrequest
  ) else $error("slave waited more than one cycle");

  // Lane status, one lane stands for all
  framing_pulse_a: assert property (
    lane_i.word_lock[0] && lane_i.frame_bad[0] |=> q.st.framing_error[0]
  ) else $error("framing error not pulsed");
  unlock_low_a: assert property (
    !lane_i.word_lock[4] |=> !q.st.locked[4]
  ) else $error("lock bit high on unlocked lane");
  sticky_len_a: assert property (
    $fell(q.st.frame_length_error[3]) |-> $rose(q.lock_q[3]) ||
      q.st.lock_failure[3] || q.st.repeat_invalid_error[3]
  ) else $error("length error cleared too early");
  // Alignment checks
  aligned_deskew_a: assert property (
    q.aligned |-> $past(deskew_i)
  ) else $error("aligned without deskew");
  give_up_a: assert property (
    give_up_i && !deskew_i |=> align_err_o
  ) else $error("give-up not flagged");
  // Packet repair checks
  missing_start_a: assert property (
    beat_i.ena && !beat_i.sop && !q.open[beat_i.chan]
      |=> missing_start_error_o
  ) else $error("missing start not reported");
  missing_end_a: assert property (
    beat_i.ena && beat_i.sop && q.open[beat_i.chan] |=> missing_end_error_o
  ) else $error("missing end not reported");
  err_on_end_a: assert property (
    beat_o.err |-> beat_o.ena && beat_o.eop
  ) else $error("packet error off the end beat");

  msop_c:  cover property (missing_start_error_o);
  meop_c:  cover property (missing_end_error_o);
  align_c: cover property ($rose(aligned_o));
  burst_c: cover property (burst_err_o);
  crc_c:   cover property (crc_err_o);

endmodule : rlse_lane_sync_status
`default_nettype wire

// ---- test/rlse_far_tx.sv ----
`default_nettype none
// Remote transmitter, seen through the lane decoders and word parser
module rlse_far_tx
  import rlse_pkg::*;
(
  input  wire logic         clk_i,  // Local bus clock
  output var rlse_lane_in_t lane_o, // Per-lane word events
  output var rlse_cw_t      cw_o,   // Control word events
  output var rlse_beat_t    beat_o  // Raw received beat
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [LANES-1:0] lock_q; // Word lock level per lane

  // Link idle at time zero
  initial begin
    lock_q = '0;
    lane_o = '0;
    cw_o   = '0;
    beat_o = '0;
  end

  // One cycle of traffic; lock level persists, stale data is inverted
  task automatic put(input rlse_lane_in_t l, input rlse_cw_t c,
                     input rlse_beat_t b);
    @(posedge clk_i);
    l.word_lock = lock_q;
    lane_o <= l;
    cw_o   <= c;
    beat_o <= b;
    @(posedge clk_i);
    l = '0;
    l.word_lock = lock_q;
    // Inverted leftovers so a stale beat never matches the last one
    b = '{ena: 1'b0, sop: 1'b0, eop: 1'b0, err: 1'b0,
          chan: ~b.chan, data: ~b.data};
    lane_o <= l;
    cw_o   <= '0;
    beat_o <= b;
  endtask : put

  // One word on the lanes in m; k picks its kind
  task automatic word(input logic [LANES-1:0] m, input int k);
    rlse_lane_in_t l;
    l = '0;
    l.word_vld = m;
    case (k)
      1: l.sw_ok = m;
      2: l.sw_bad = m;
      3: l.ss_ok = m;
      4: l.ss_bad = m;
      5: l.frame_bad = m;
      6: l.lock_fail = m;
      default: ;
    endcase
    put(l, '0, '0);
  endtask : word

  // New word lock levels, no word
  task automatic lock(input logic [LANES-1:0] m);
    lock_q = m;
    put('0, '0, '0);
  endtask : lock
endmodule : rlse_far_tx
`default_nettype wire

// ---- test/testbench.sv ----
`default_nettype none
module testbench
  import rlse_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic            clk_i = 1'b0;
  logic            rst_i = 1'b1;
  logic            deskew = 1'b0;   // All lanes deskewed
  logic            give_up = 1'b0;  // Alignment attempts exhausted
  logic [3:0]      avs_address = '0;
  logic            avs_read = 1'b0;
  logic            avs_write = 1'b0;
  logic [31:0]     avs_writedata = '0;
  logic [31:0]     avs_readdata;
  logic            avs_waitrequest;
  logic [31:0]     rd;              // Last read data
  rlse_lane_in_t   lane;
  rlse_cw_t        cw;
  rlse_beat_t      beat, bo;        // Raw and repaired beats
  rlse_lane_stat_t st;
  logic            aligned, align_err, crc_err, burst_err, msop, meop;
  int              n_errors = 0;
  int              n_checks = 0;

  // 100 MHz clock
  always #5 clk_i = ~clk_i;

  rlse_far_tx far_u (.clk_i(clk_i), .lane_o(lane), .cw_o(cw),
                     .beat_o(beat));

  rlse_lane_sync_status dut_u (
    .clk_i(clk_i), .rst_i(rst_i), .lane_i(lane), .deskew_i(deskew),
    .give_up_i(give_up), .cw_i(cw), .beat_i(beat),
    .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .lane_stat_o(st), .aligned_o(aligned), .align_err_o(align_err),
    .crc_err_o(crc_err), .burst_err_o(burst_err),
    .missing_start_error_o(msop), .missing_end_error_o(meop),
    .beat_o(bo));

  // Compare and count
  task automatic chk(input string nm, input logic [63:0] s,
                     input logic [63:0] e);
    n_checks++;
    if (s !== e) begin
      n_errors++;
      $display("unexpected %s: expected %0h seen %0h", nm, e, s);
    end
  endtask : chk

  // One Avalon transfer, held until waitrequest is seen low
  task automatic av(input logic wr, input logic [3:0] a,
                    input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    avs_address   <= a;
    avs_writedata <= d;
    avs_write     <= wr;
    avs_read      <= ~wr;
    do begin
      @(posedge clk_i);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    if (n >= 50) n_errors++;
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
  endtask : av

  // Lane word, then let the edge's updates land
  task automatic wd(input logic [LANES-1:0] m, input int k);
    far_u.word(m, k);
    #1;
  endtask : wd

  // Word lock levels
  task automatic lk(input logic [LANES-1:0] m);
    far_u.lock(m);
    #1;
  endtask : lk

  // Sync word, second word of kind k, n plain words
  task automatic frame(input logic [LANES-1:0] m, input int k, int n);
    wd(m, 1);
    wd(m, k);
    repeat (n) wd(m, 0);
  endtask : frame

  // One beat on channel ch
  task automatic bt(input logic [3:0] ch, input logic s, input logic e);
    far_u.put('0, '0, '{ena: 1'b1, sop: s, eop: e, err: 1'b0,
                        chan: ch, data: {16{ch}}});
    #1;
  endtask : bt

  // One control word
  task automatic cwd(input logic bu, input logic bad);
    far_u.put('0, '{valid: 1'b1, burst: bu, crc_bad: bad}, '0);
    #1;
  endtask : cwd

  // New deskew level, give-up for one cycle
  task automatic drv(input logic d, input logic g);
    @(posedge clk_i);
    deskew  <= d;
    give_up <= g;
    @(posedge clk_i);
    give_up <= 1'b0;
    #1;
  endtask : drv

  // Verdict
  task automatic final_report;
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : final_report

  // Hang guard, far beyond the expected run
  initial begin
    repeat (20000) @(posedge clk_i);
    n_errors++;
    final_report();
  end

  initial begin
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    // Reset values, read-only and unmapped places
    av(1'b0, REG_MFLEN, '0);
    chk("mflen", rd, 64'h800);
    av(1'b0, REG_BSHORT, '0);
    chk("bshort", rd, 64'h40);
    av(1'b1, REG_LANE, 32'hFFF);
    av(1'b0, REG_LANE, '0);
    chk("lane reg", rd, 64'h0);
    av(1'b0, 4'h6, '0);
    chk("unmapped", rd, 64'h0);
    av(1'b1, REG_MFLEN, 32'h8);
    av(1'b0, REG_MFLEN, '0);
    chk("mflen wr", rd, 64'h8);
    av(1'b1, REG_BSHORT, 32'h48);
    av(1'b0, REG_BSHORT, '0);
    chk("bshort wr", rd, 64'h48);
    // No lane pulses before word lock
    wd(12'h001, 4);
    chk("descram", st.descrambler_error, 64'h0);
    wd(12'h001, 2);
    chk("syncword", st.sync_word_error, 64'h0);
    wd(12'h001, 5);
    chk("framing", st.framing_error, 64'h0);
    // Lock all lanes with well-spaced frames
    lk(12'hFFF);
    frame(12'hFFF, 3, 6);
    frame(12'hFFF, 3, 6);
    chk("locked", st.locked, 64'hFFF);
    av(1'b0, REG_LANE, '0);
    chk("lane reg", rd, 64'hFFF);
    // Give-up, alignment, loss, realignment
    drv(1'b0, 1'b1);
    chk("align err", align_err, 64'h1);
    drv(1'b1, 1'b0);
    chk("aligned", aligned, 64'h1);
    chk("align err", align_err, 64'h0);
    av(1'b0, REG_ALIGN, '0);
    chk("align reg", rd, 64'h1);
    drv(1'b0, 1'b0);
    chk("align err", align_err, 64'h1);
    chk("aligned", aligned, 64'h0);
    drv(1'b1, 1'b0);
    // CRC24 error errors the open packet
    bt(4'h1, 1'b1, 1'b0);
    cwd(1'b0, 1'b1);
    chk("crc err", crc_err, 64'h1);
    @(posedge clk_i);
    #1;
    chk("crc err", crc_err, 64'h0);
    bt(4'h1, 1'b0, 1'b1);
    chk("pkt err", bo.err, 64'h1);
    // Data on a closed channel
    bt(4'h2, 1'b0, 1'b0);
    chk("msop", msop, 64'h1);
    chk("sop ins", bo.sop, 64'h1);
    bt(4'h2, 1'b0, 1'b1);
    chk("pkt err", bo.err, 64'h1);
    // Start on an open channel
    bt(4'h3, 1'b1, 1'b0);
    bt(4'h3, 1'b1, 1'b0);
    chk("meop", meop, 64'h1);
    chk("sop del", bo.sop, 64'h0);
    bt(4'h3, 1'b0, 1'b1);
    chk("pkt err", bo.err, 64'h1);
    // Clean packet passes unmarked
    bt(4'h4, 1'b1, 1'b0);
    bt(4'h4, 1'b0, 1'b1);
    chk("pkt err", bo.err, 64'h0);
    chk("data", bo.data, {16{4'h4}});
    // Burst words closer than BurstShort
    bt(4'h6, 1'b1, 1'b0);
    cwd(1'b1, 1'b0);
    cwd(1'b1, 1'b0);
    chk("burst err", burst_err, 64'h1);
    bt(4'h6, 1'b0, 1'b1);
    chk("pkt err", bo.err, 64'h1);
    // Nine-word burst without end: not a bus multiple
    cwd(1'b1, 1'b0);
    bt(4'h7, 1'b1, 1'b0);
    repeat (8) bt(4'h7, 1'b0, 1'b0);
    cwd(1'b1, 1'b0);
    chk("burst err", burst_err, 64'h1);
    bt(4'h7, 1'b0, 1'b1);
    chk("pkt err", bo.err, 64'h1);
    // Framing fault while aligned acts like CRC24
    bt(4'h5, 1'b1, 1'b0);
    wd(12'h001, 5);
    chk("framing", st.framing_error, 64'h1);
    chk("lock fail", st.lock_failure[0], 64'h1);
    bt(4'h5, 1'b0, 1'b1);
    chk("pkt err", bo.err, 64'h1);
    // Lock cannot be reached on lane 4
    lk(12'hFEF);
    wd(12'h010, 6);
    chk("lock fail", st.lock_failure[4], 64'h1);
    chk("locked", st.locked[4], 64'h0);
    // Three bad scrambler words on lane 2
    for (int i = 1; i <= 3; i++) begin
      wd(12'h004, 1);
      wd(12'h004, 4);
      chk("descram", st.descrambler_error, 64'h4);
      chk("repeat", st.repeat_invalid_error[2], i == 3);
      wd(12'h004, 0);
      chk("descram", st.descrambler_error, 64'h0);
      repeat (5) wd(12'h004, 0);
    end
    chk("locked", st.locked[2], 64'h0);
    // Bad sync word pulse on lane 1
    wd(12'h002, 2);
    chk("syncword", st.sync_word_error, 64'h2);
    wd(12'h002, 0);
    chk("syncword", st.sync_word_error, 64'h0);
    // Short meta frame on lane 3
    wd(12'h008, 1);
    repeat (3) wd(12'h008, 0);
    wd(12'h008, 1);
    chk("len err", st.frame_length_error, 64'h8);
    chk("locked", st.locked[3], 64'h0);
    repeat (6) wd(12'h008, 0);
    chk("len err", st.frame_length_error, 64'h8);
    // Relock clears the sticky bits
    lk(12'hFF3);
    lk(12'hFFF);
    chk("len err", st.frame_length_error, 64'h0);
    chk("repeat", st.repeat_invalid_error, 64'h0);
    // No sync word within a frame after relock
    repeat (9) wd(12'h004, 0);
    chk("lock fail", st.lock_failure[2], 64'h1);
    final_report();
  end
endmodule : testbench
`default_nettype wire
